// >>> hw/ccg_pkg.sv
// Package with the constants and types of the CPU clock generator.
package ccg_pkg;

    typedef enum logic [1:0] {
        CCG_PLL,
        CCG_DIRECT,
        CCG_PRESCALE
    } ccg_mode_e;

    localparam logic [2:0] CFG_MUL4 = 3'h7;
    localparam logic [2:0] CFG_MUL3 = 3'h6;
    localparam logic [2:0] CFG_MUL2 = 3'h5;
    localparam logic [2:0] CFG_MUL5 = 3'h4;
    localparam logic [2:0] CFG_DIRECT = 3'h3;
    localparam logic [2:0] CFG_MUL1P5 = 3'h2;
    localparam logic [2:0] CFG_PRESCALE = 3'h1;
    localparam logic [2:0] CFG_MUL2P5 = 3'h0;

    localparam logic [15:0] INC_RESET = 16'h0800;
    localparam logic [15:0] INC_STEP = 16'h0010;
    localparam logic [15:0] INC_MIN = 16'h0010;
    localparam logic [15:0] INC_MAX = 16'h7000;
    localparam logic [15:0] PHASE_STEP = 16'h0100;
    localparam logic [7:0] PHASE_LOW = 8'h7F;
    localparam logic [7:0] PHASE_HIGH = 8'h80;

endpackage

// >>> hw/ccg_decode.sv
// Decoder from the clock configuration field to mode and frequency ratio.
`timescale 1ns/1ps
`default_nettype none

module ccg_decode (
    input wire logic [2:0] clock_config_field,
    output ccg_pkg::ccg_mode_e mode,
    output logic [3:0] ratio_num,
    output logic [1:0] ratio_den
);

    // The ratio is num/den cycles of the CPU clock per input clock period.
    always_comb begin
        mode = ccg_pkg::CCG_PLL;
        ratio_num = 4'h1;
        ratio_den = 2'h1;
        unique case (clock_config_field)
            ccg_pkg::CFG_MUL4: begin
                ratio_num = 4'h4;
            end
            ccg_pkg::CFG_MUL3: begin
                ratio_num = 4'h3;
            end
            ccg_pkg::CFG_MUL2: begin
                ratio_num = 4'h2;
            end
            ccg_pkg::CFG_MUL5: begin
                ratio_num = 4'h5;
            end
            ccg_pkg::CFG_DIRECT: begin
                mode = ccg_pkg::CCG_DIRECT;
            end
            ccg_pkg::CFG_MUL1P5: begin
                ratio_num = 4'h3;
                ratio_den = 2'h2;
            end
            ccg_pkg::CFG_PRESCALE: begin
                mode = ccg_pkg::CCG_PRESCALE;
            end
            ccg_pkg::CFG_MUL2P5: begin
                ratio_num = 4'h5;
                ratio_den = 2'h2;
            end
        endcase
    end

endmodule

`default_nettype wire

// >>> hw/ccg_top.sv
// CPU clock generator: configuration capture, prescaler, direct drive and digital PLL.
`timescale 1ns/1ps
`default_nettype none

module ccg_top (
    input wire logic mclk,
    input wire logic srst,
    input wire logic osc_in,
    input wire logic [2:0] port0_upper_byte_hi,
    output logic cpu_clk,
    output logic pll_enable,
    output logic pll_locked,
    output logic [2:0] clock_config_field
);

    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_prev_q;
    logic [2:0] cfg_s1_q;
    logic [2:0] cfg_s2_q;
    logic [2:0] cfg_q;
    logic presc_q;
    logic [15:0] acc_q;
    logic [15:0] inc_q;
    logic dco_prev_q;
    logic [7:0] cyc_q;
    logic [1:0] win_q;
    logic cpu_clk_q;
    logic pll_enable_q;
    logic pll_locked_q;
    ccg_pkg::ccg_mode_e mode;
    logic [3:0] ratio_num;
    logic [1:0] ratio_den;
    logic osc_rise;
    logic dco_clk;
    logic dco_rise;
    logic win_end;
    logic [7:0] cyc_total;
    logic [7:0] num_ext;

    // Both the oscillator and the strap pins are asynchronous to mclk.
    always_ff @(posedge mclk) begin
        osc_s1_q <= osc_in;
        osc_s2_q <= osc_s1_q;
    end

    always_ff @(posedge mclk) begin
        cfg_s1_q <= port0_upper_byte_hi;
        cfg_s2_q <= cfg_s1_q;
    end

    // The edge detector follows the pin through reset, so a high input at release is no false edge.
    always_ff @(posedge mclk) begin
        osc_prev_q <= osc_s2_q;
    end

    always_comb begin
        osc_rise = 1'b0;
        if (osc_s2_q && !osc_prev_q) begin
            osc_rise = 1'b1;
        end
    end

    // The straps are sampled on every clock while reset is held, so the value at release stays.
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_q <= cfg_s2_q;
        end
    end

    ccg_decode u_decode (
        .clock_config_field(cfg_q),
        .mode(mode),
        .ratio_num(ratio_num),
        .ratio_den(ratio_den)
    );

    // Toggling on each input rising edge makes every half phase one input period long.
    always_ff @(posedge mclk) begin
        if (srst) begin
            presc_q <= 1'b0;
        end else if (osc_rise) begin
            presc_q <= ~presc_q;
        end
    end

    assign dco_clk = acc_q[15];
    assign dco_rise = dco_clk & ~dco_prev_q;
    assign num_ext = {4'h0, ratio_num};

    // A window closes on the input edge that completes ratio_den input periods.
    always_comb begin
        win_end = 1'b0;
        if (osc_rise && win_q == ratio_den - 2'h1) begin
            win_end = 1'b1;
        end
    end

    // Saturating keeps a runaway oscillator from wrapping the count back to a small value.
    always_comb begin
        cyc_total = cyc_q;
        if (dco_rise && cyc_q != 8'hFF) begin
            cyc_total = cyc_q + 8'h01;
        end
    end

    // Window of ratio_den input periods, which should hold ratio_num CPU cycles.
    always_ff @(posedge mclk) begin
        if (srst) begin
            win_q <= 2'h0;
        end else if (win_end) begin
            win_q <= 2'h0;
        end else if (osc_rise) begin
            win_q <= win_q + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            dco_prev_q <= 1'b0;
        end else begin
            dco_prev_q <= dco_clk;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cyc_q <= 8'h00;
        end else if (win_end) begin
            cyc_q <= 8'h00;
        end else begin
            cyc_q <= cyc_total;
        end
    end

    // Frequency moves by one small step per window, never by a jump.
    always_ff @(posedge mclk) begin
        if (srst) begin
            inc_q <= ccg_pkg::INC_RESET;
        end else if (win_end && mode == ccg_pkg::CCG_PLL) begin
            if (cyc_total < num_ext && inc_q < ccg_pkg::INC_MAX) begin
                inc_q <= inc_q + ccg_pkg::INC_STEP;
            end else if (cyc_total > num_ext && inc_q > ccg_pkg::INC_MIN) begin
                inc_q <= inc_q - ccg_pkg::INC_STEP;
            end
        end
    end

    // Phase is nudged by a fraction of a cycle per window toward an edge on the input edge.
    always_ff @(posedge mclk) begin
        if (srst) begin
            acc_q <= 16'h0000;
        end else if (win_end && mode == ccg_pkg::CCG_PLL && cyc_total == num_ext) begin
            if (acc_q[15:8] < ccg_pkg::PHASE_LOW) begin
                acc_q <= acc_q + inc_q + ccg_pkg::PHASE_STEP;
            end else if (acc_q[15:8] > ccg_pkg::PHASE_HIGH) begin
                acc_q <= acc_q + inc_q - ccg_pkg::PHASE_STEP;
            end else begin
                acc_q <= acc_q + inc_q;
            end
        end else begin
            acc_q <= acc_q + inc_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pll_locked_q <= 1'b0;
        end else if (mode != ccg_pkg::CCG_PLL) begin
            pll_locked_q <= 1'b0;
        end else if (win_end) begin
            pll_locked_q <= (cyc_total == num_ext);
        end
    end

    // The enable is a level; the mode cannot change until the next reset.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pll_enable_q <= 1'b0;
        end else begin
            pll_enable_q <= (mode == ccg_pkg::CCG_PLL);
        end
    end

    // Each source is re-registered so the output changes only on mclk; its edges are quantised to it.
    always_ff @(posedge mclk) begin
        if (srst) begin
            cpu_clk_q <= 1'b0;
        end else begin
            unique case (mode)
                ccg_pkg::CCG_PLL: begin
                    cpu_clk_q <= dco_clk;
                end
                ccg_pkg::CCG_DIRECT: begin
                    cpu_clk_q <= osc_s2_q;
                end
                ccg_pkg::CCG_PRESCALE: begin
                    cpu_clk_q <= presc_q;
                end
                default: begin
                    cpu_clk_q <= 1'b0;
                end
            endcase
        end
    end

    assign cpu_clk = cpu_clk_q;
    assign pll_enable = pll_enable_q;
    assign pll_locked = pll_locked_q;
    assign clock_config_field = cfg_q;

endmodule

`default_nettype wire

// >>> test/ccg_top_sva.sv
// Assertion checker for the CPU clock generator ports.
`timescale 1ns/1ps
`default_nettype none
module ccg_top_sva (
    input wire logic mclk,
    input wire logic srst,
    input wire logic osc_in,
    input wire logic [2:0] port0_upper_byte_hi,
    input wire logic cpu_clk,
    input wire logic pll_enable,
    input wire logic pll_locked,
    input wire logic [2:0] clock_config_field
);
    default clocking @(posedge mclk); endclocking
    logic [2:0] run_q;
    logic pre;
    logic dir;
    // Settle time after reset so the input synchronisers hold real history.
    always_ff @(posedge mclk) begin
        if (srst) run_q <= 3'h0;
        else if (run_q != 3'h7) run_q <= run_q + 3'h1;
    end
    assign pre = clock_config_field == ccg_pkg::CFG_PRESCALE && run_q == 3'h7;
    assign dir = clock_config_field == ccg_pkg::CFG_DIRECT && run_q == 3'h7;
    sequence presc_turn;
        ##4 $changed(cpu_clk);
    endsequence
    a_reset_quiet: assert property (srst |=> !cpu_clk && !pll_enable && !pll_locked)
        else $error("output active in reset");
    a_cfg_pipe: assert property (srst [*4] |-> clock_config_field == $past(port0_upper_byte_hi, 3))
        else $error("config not taken from pins");
    a_cfg_hold: assert property (disable iff (srst) !srst |=> $stable(clock_config_field))
        else $error("config moved after reset");
    a_pll_mode: assert property (disable iff (srst) !srst |=> pll_enable ==
        (clock_config_field != ccg_pkg::CFG_DIRECT && clock_config_field != ccg_pkg::CFG_PRESCALE))
        else $error("pll enable wrong for mode");
    a_presc_step: assert property (disable iff (srst) pre && $rose(osc_in) |-> presc_turn)
        else $error("prescaler did not toggle");
    a_presc_hold: assert property (disable iff (srst) pre && $fell(osc_in) |=> $stable(cpu_clk) [*8])
        else $error("prescaler toggled on falling input");
    a_direct_copy: assert property (disable iff (srst) dir |-> cpu_clk == $past(osc_in, 3))
        else $error("direct drive mismatch");
    a_pll_rate: assert property (disable iff (srst) pll_enable && $changed(cpu_clk) |=> $stable(cpu_clk))
        else $error("pll output too fast");
    a_lock_in_pll: assert property (disable iff (srst) pll_locked |-> pll_enable)
        else $error("lock outside pll mode");
endmodule
bind ccg_top ccg_top_sva ccg_top_sva_i (.mclk(mclk), .srst(srst), .osc_in(osc_in),
    .port0_upper_byte_hi(port0_upper_byte_hi), .cpu_clk(cpu_clk), .pll_enable(pll_enable),
    .pll_locked(pll_locked), .clock_config_field(clock_config_field));
`default_nettype wire

// >>> test/ccg_osc_model.sv
// Free-running oscillator that feeds the clock generator input.
`timescale 1ns/1ps
`default_nettype none
module ccg_osc_model #(
    parameter int HALF_NS = 1000
) (
    output var logic osc
);
    // The odd start offset keeps the edges clear of the system clock edges.
    initial begin
        osc = 1'b0;
        #13;
        forever #(HALF_NS) osc = ~osc;
    end
endmodule
`default_nettype wire

// >>> test/tb_ccg_top.sv
// Self-checking testbench for the CPU clock generator.
`timescale 1ns/1ps
`default_nettype none
module tb_ccg_top;
    logic mclk, srst, osc_in, cpu_clk, pll_enable, pll_locked, prev;
    logic [2:0] pins, cfg;
    logic [1:0] oh;
    // Each PLL case is a multiplier code and the CPU clock edges expected in 800 cycles.
    logic [2:0] pcode [2] = '{ccg_pkg::CFG_MUL4, ccg_pkg::CFG_MUL1P5};
    int pedge [2] = '{80, 30};
    int fails = 0, n_compared = 0, cyc = 0, n;
    // Each row is the code followed by the expected pll enable.
    logic [3:0] rows [8] = '{4'hF, 4'hD, 4'hB, 4'h9, 4'h6, 4'h5, 4'h2, 4'h1};
    ccg_osc_model ccg_osc_model_i (.osc(osc_in));
    ccg_top ccg_top_i (.mclk(mclk), .srst(srst), .osc_in(osc_in), .port0_upper_byte_hi(pins),
        .cpu_clk(cpu_clk), .pll_enable(pll_enable), .pll_locked(pll_locked), .clock_config_field(cfg));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #5;
    endtask
    task automatic boot(input logic [2:0] code);
        pins = code;
        srst = 1'b1;
        tick(12);
        srst = 1'b0;
        tick(2);
    endtask
    initial begin
        foreach (rows[i]) begin
            boot(rows[i][3:1]);
            check(8'(cfg), 8'(rows[i][3:1]));
            check(8'(pll_enable), 8'(rows[i][0]));
            pins = ~rows[i][3:1];
            tick(5);
            check(8'(cfg), 8'(rows[i][3:1]));
            $display("row %0d done", i);
        end
        // High and low phase must each span one 40-cycle input period.
        boot(ccg_pkg::CFG_PRESCALE);
        @(posedge cpu_clk);
        for (int p = 1; p >= 0; p--) begin
            n = 0;
            while (cpu_clk === 1'(p) && n < 200) begin
                tick(1);
                n++;
            end
            check(8'(n), 8'h28);
        end
        $display("prescaler done");
        // Direct drive shows the pin two samples late at this point of the cycle.
        boot(ccg_pkg::CFG_DIRECT);
        n = 0;
        oh = 2'h0;
        for (int j = 0; j < 120; j++) begin
            tick(1);
            if (j >= 2 && cpu_clk !== oh[1]) n++;
            oh = {oh[0], osc_in};
        end
        check(8'(n), 8'h00);
        $display("direct done");
        // Lock is slow because the frequency moves one small step per window.
        foreach (pcode[k]) begin
            boot(pcode[k]);
            n = 0;
            while (pll_locked !== 1'b1 && n < 20000) begin
                tick(1);
                n++;
            end
            check(8'(pll_locked), 8'h01);
            // The first lock comes before the frequency has settled, so spans are counted until one fits.
            for (int t = 0; t < 25; t++) begin
                n = 0;
                prev = cpu_clk;
                repeat (800) begin
                    tick(1);
                    if (cpu_clk && !prev) n++;
                    prev = cpu_clk;
                end
                if (n >= pedge[k] - 1 && n <= pedge[k] + 1) break;
            end
            check(8'(n >= pedge[k] - 1 && n <= pedge[k] + 1), 8'h01);
            $display("pll case %0d done", k);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
